//--- adt_calc_if.sv
// interface between the trigger core and its scaling stage
`timescale 1ns/1ns
interface adt_calc_if;
  logic start; // sample accepted, one-cycle pulse
  logic signed [15:0] sample; // selected input value
  logic signed [15:0] gain; // hundredths
  logic signed [31:0] offset; // added after scaling
  logic signed [31:0] on_level; // upper switching level
  logic signed [31:0] delta; // signed hysteresis width
  logic done; // working value valid, one-cycle pulse
  logic signed [31:0] working; // scaled working value
  logic signed [31:0] off_level; // derived release level
  modport master (output start, sample, gain, offset, on_level, delta,
                  input done, working, off_level);
  modport worker (input start, sample, gain, offset, on_level, delta,
                  output done, working, off_level);
endinterface

//--- adt_pkg.sv
// constants, register map and types of the analog differential trigger
// ============================================================================
// Summary of operation
// R01 - working value is sample times gain plus offset
// R02 - gain signed hundredths, minus ten to ten
// R03 - offset integer, minus to plus ten thousand
// R04 - switching level integer, plus/minus twenty thousand
// R05 - differential integer, plus/minus twenty thousand
// R06 - release level is switching level plus differential
// R07 - negative differential: above switching level sets output
// R08 - negative differential: at/below release level clears output
// R09 - negative differential: between levels output holds
// R10 - positive differential: high inside half-open window
// R11 - positive differential: low outside the window
// R12 - decimal places setting holds zero to three
// R13 - decimal places never affect the comparison
// R14 - physical channel: zero to ten volts is 0..1000
// R15 - older generation: gain limited to zero..ten
// ============================================================================
package adt_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADT_ADDR_CTRL = 8'h00; // control bits
  localparam logic [7:0] ADT_ADDR_GAIN = 8'h04; // gain, hundredths
  localparam logic [7:0] ADT_ADDR_OFFSET = 8'h08; // offset
  localparam logic [7:0] ADT_ADDR_ON = 8'h0C; // upper switching level
  localparam logic [7:0] ADT_ADDR_DELTA = 8'h10; // hysteresis width
  localparam logic [7:0] ADT_ADDR_STATUS = 8'h14; // result and mode, read only
  localparam logic [7:0] ADT_ADDR_WORK = 8'h18; // working value, read only
  localparam logic [7:0] ADT_ADDR_OFF = 8'h1C; // derived release level, read only

  // ==========================================================================
  // control field positions and reset values
  localparam int ADT_CTRL_RUN = 0; // evaluate incoming samples
  localparam int ADT_CTRL_LEGACY = 1; // older-generation gain range
  localparam int ADT_CTRL_PHYS = 2; // source is a physical channel
  localparam int ADT_CTRL_DEC_LSB = 4; // decimal places, two bits
  localparam logic [31:0] ADT_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] ADT_GAIN_RST = 32'h0000_0064; // gain 1.00
  localparam logic [31:0] ADT_ZERO_RST = 32'h0000_0000;

  // ==========================================================================
  // value limits
  localparam int ADT_GAIN_SCALE = 100; // two fractional digits
  localparam int ADT_GAIN_MAX = 1000;
  localparam int ADT_GAIN_MIN = -1000;
  localparam int ADT_GAIN_LEG_MIN = 0;
  localparam int ADT_OFFS_LIM = 10000;
  localparam int ADT_LEVEL_LIM = 20000;
  localparam int ADT_PHYS_MAX = 1000; // internal value at full scale

  // axi response codes
  localparam logic [1:0] ADT_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADT_RESP_SLVERR = 2'h2;

  // output state, gray along off -> on
  typedef enum logic [1:0] {
    ADT_Q_OFF = 2'b00,
    ADT_Q_ON = 2'b01
  } adt_q_t;

  // inclusive signed range check
  function automatic logic adt_in_range(input logic signed [31:0] v, input int lo, input int hi);
    adt_in_range = (v >= lo) && (v <= hi);
  endfunction

endpackage

//--- adt_scale.sv
// scaling stage: working value and derived release level
`timescale 1ns/1ns
module adt_scale
  import adt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // calculation link
  adt_calc_if.worker calc
);

  // ==========================================================================
  // arithmetic
  logic signed [31:0] product; // sample times gain
  logic signed [31:0] scaled; // product in whole units
  logic signed [31:0] working_reg;
  logic signed [31:0] off_level_reg;
  logic done_reg;

  always_comb begin
    product = 32'(calc.sample) * 32'(calc.gain); // see R01
    scaled = product / ADT_GAIN_SCALE; // drop the two fractional digits
  end

  // working value latched when a sample is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_reg <= '0;
    end else if (calc.start) begin
      working_reg <= scaled + calc.offset; // see R01
    end
  end

  // release level always follows the two settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_level_reg <= '0;
    end else begin
      off_level_reg <= calc.on_level + calc.delta; // see R06
    end
  end

  // completion strobe one cycle after start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= calc.start;
    end
  end

  assign calc.working = working_reg;
  assign calc.off_level = off_level_reg;
  assign calc.done = done_reg;

  // ==========================================================================
  // checks
  a_off_level_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    $stable(calc.on_level) && $stable(calc.delta) |=>
      calc.off_level == $past(calc.on_level) + $past(calc.delta)) // see R06
    else $error("release level is not switching level plus width");
  a_work_formula: assert property (@(posedge aclk) disable iff (!aresetn)
    calc.start |=> calc.done && calc.working ==
      ($past(calc.sample) * $past(calc.gain)) / 100 + $past(calc.offset)) // see R01
    else $error("working value wrong after sample");

endmodule // adt_scale

//--- adt_src_model.sv
// far-side model: an analog source that hands one sample per request
`timescale 1ns/1ns
module adt_src_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request from the bench
  input wire logic go,
  input wire logic [15:0] val,
  // sample link
  output logic [15:0] sampled_value,
  output logic sampled_valid
);
  logic [3:0] cnt_reg; // steps left in one sample frame

  // ==========================================================================
  // value leads valid by two cycles and outlives its rise by six
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      sampled_valid <= 1'b0;
      sampled_value <= 16'h5555;
    end else if (go && cnt_reg == 4'h0) begin
      cnt_reg <= 4'h8;
      sampled_value <= val;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      sampled_valid <= (cnt_reg <= 4'h7) && (cnt_reg >= 4'h3);
      // hold time over: show a changed value, never the stale one
      if (cnt_reg == 4'h1) begin
        sampled_value <= ~sampled_value;
      end
    end
  end
endmodule // adt_src_model

//--- adt_trigger.sv
// analog differential trigger with axi4-lite register access
`timescale 1ns/1ns
module adt_trigger
  import adt_pkg::*;
#(
  parameter int SAMPLE_W = 16 // width of the incoming sample bus
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog sample from a channel or another block
  input wire logic [SAMPLE_W-1:0] sampled_value,
  input wire logic sampled_valid,
  // binary result
  output logic trig_out
);

  // ==========================================================================
  // elaboration check
  generate
    if (SAMPLE_W < 12 || SAMPLE_W > 16) begin : g_bad_width
      $error("SAMPLE_W must lie between 12 and 16");
    end
  endgenerate

  // ==========================================================================
  // settings registers
  logic [31:0] ctrl_reg; // run, legacy, physical, decimals
  logic signed [31:0] gain_reg; // hundredths
  logic signed [31:0] offset_reg;
  logic signed [31:0] on_reg; // upper switching level
  logic signed [31:0] delta_reg; // hysteresis width
  logic [1:0] decimals; // display only

  // ==========================================================================
  // write channel state
  logic aw_held_reg; // address taken, waiting for data
  logic w_held_reg; // data taken, waiting for address
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_take; // address handshake this cycle
  logic w_take; // data handshake this cycle
  logic wr_fire; // both halves present
  logic [7:0] wr_addr; // address of the write now done
  logic [31:0] wr_data; // merged data of that write
  logic wr_ok; // value legal for its register

  // each channel free while its half is not held and no response is pending
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);

  // hold whichever half came first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // merge byte lanes into the current register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // legality of the write about to land
  always_comb begin
    logic [31:0] nw;
    logic [3:0] st;
    nw = w_held_reg ? w_data_reg : s_axi_wdata;
    st = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wr_data = '0;
    wr_ok = 1'b0;
    case (wr_addr)
      ADT_ADDR_CTRL: begin
        wr_data = merge(ctrl_reg, nw, st);
        wr_ok = 1'b1; // two-bit decimals field takes 0..3 only, see R12
      end
      ADT_ADDR_GAIN: begin
        wr_data = merge(gain_reg, nw, st);
        // older generation refuses negative gain, see R15
        wr_ok = adt_in_range(wr_data, ctrl_reg[ADT_CTRL_LEGACY] ? ADT_GAIN_LEG_MIN : ADT_GAIN_MIN,
                             ADT_GAIN_MAX); // see R02
      end
      ADT_ADDR_OFFSET: begin
        wr_data = merge(offset_reg, nw, st);
        wr_ok = adt_in_range(wr_data, -ADT_OFFS_LIM, ADT_OFFS_LIM); // see R03
      end
      ADT_ADDR_ON: begin
        wr_data = merge(on_reg, nw, st);
        wr_ok = adt_in_range(wr_data, -ADT_LEVEL_LIM, ADT_LEVEL_LIM); // see R04
      end
      ADT_ADDR_DELTA: begin
        wr_data = merge(delta_reg, nw, st);
        wr_ok = adt_in_range(wr_data, -ADT_LEVEL_LIM, ADT_LEVEL_LIM); // see R05
      end
      default: begin
        wr_ok = 1'b0; // read-only or unmapped
      end
    endcase
  end

  // settings update on a legal write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ADT_CTRL_RST;
      gain_reg <= ADT_GAIN_RST;
      offset_reg <= ADT_ZERO_RST;
      on_reg <= ADT_ZERO_RST;
      delta_reg <= ADT_ZERO_RST;
    end else if (wr_fire && wr_ok) begin
      case (wr_addr)
        ADT_ADDR_CTRL: ctrl_reg <= wr_data & 32'h0000_0037;
        ADT_ADDR_GAIN: gain_reg <= wr_data;
        ADT_ADDR_OFFSET: offset_reg <= wr_data;
        ADT_ADDR_ON: on_reg <= wr_data;
        ADT_ADDR_DELTA: delta_reg <= wr_data;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end else if (wr_fire && wr_addr == ADT_ADDR_GAIN && ctrl_reg[ADT_CTRL_LEGACY]) begin
      gain_reg <= gain_reg; // refused legacy gain leaves the old value
    end
  end

  // write response, held until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ADT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? ADT_RESP_OKAY : ADT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign decimals = ctrl_reg[ADT_CTRL_DEC_LSB +: 2]; // kept out of the compare, see R13

  // ==========================================================================
  // sample input, two flip-flops before any logic
  logic [SAMPLE_W-1:0] samp_s1_reg;
  logic [SAMPLE_W-1:0] samp_s2_reg;
  logic vld_s1_reg;
  logic vld_s2_reg;
  logic vld_s3_reg; // edge detect on the synchronised level
  logic signed [15:0] samp_sel; // clamped, widened sample

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_s1_reg <= '0;
      samp_s2_reg <= '0;
      vld_s1_reg <= 1'b0;
      vld_s2_reg <= 1'b0;
      vld_s3_reg <= 1'b0;
    end else begin
      samp_s1_reg <= sampled_value;
      samp_s2_reg <= samp_s1_reg;
      vld_s1_reg <= sampled_valid;
      vld_s2_reg <= vld_s1_reg;
      vld_s3_reg <= vld_s2_reg;
    end
  end

  // physical channels span 0..1000, see R14
  always_comb begin
    logic signed [15:0] raw;
    raw = 16'($signed(samp_s2_reg));
    samp_sel = raw;
    if (ctrl_reg[ADT_CTRL_PHYS]) begin
      if (raw < 0) begin
        samp_sel = '0;
      end else if (raw > ADT_PHYS_MAX) begin
        samp_sel = 16'(ADT_PHYS_MAX);
      end
    end
  end

  // ==========================================================================
  // scaling stage
  adt_calc_if calc ();
  assign calc.start = vld_s2_reg && !vld_s3_reg && ctrl_reg[ADT_CTRL_RUN];
  assign calc.sample = samp_sel;
  assign calc.gain = gain_reg[15:0];
  assign calc.offset = offset_reg;
  assign calc.on_level = on_reg;
  assign calc.delta = delta_reg;

  adt_scale u_scale (
    .aclk(aclk),
    .aresetn(aresetn),
    .calc(calc)
  );

  // ==========================================================================
  // output decision, once per evaluated sample
  adt_q_t q_state;
  logic hyst_mode; // release level at or below switching level

  assign hyst_mode = (calc.off_level <= on_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_state <= ADT_Q_OFF;
    end else if (calc.done) begin
      if (hyst_mode) begin
        if (calc.working > on_reg) begin
          q_state <= ADT_Q_ON; // see R07
        end else if (calc.working <= calc.off_level) begin
          q_state <= ADT_Q_OFF; // see R08
        end else begin
          q_state <= q_state; // see R09
        end
      end else if (calc.working >= on_reg && calc.working < calc.off_level) begin
        q_state <= ADT_Q_ON; // see R10
      end else begin
        q_state <= ADT_Q_OFF; // see R11
      end
    end
  end

  assign trig_out = (q_state == ADT_Q_ON);

  // ==========================================================================
  // read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= ADT_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= ADT_RESP_OKAY;
      case (s_axi_araddr)
        ADT_ADDR_CTRL: rdata_reg <= ctrl_reg;
        ADT_ADDR_GAIN: rdata_reg <= gain_reg;
        ADT_ADDR_OFFSET: rdata_reg <= offset_reg;
        ADT_ADDR_ON: rdata_reg <= on_reg;
        ADT_ADDR_DELTA: rdata_reg <= delta_reg;
        ADT_ADDR_STATUS: rdata_reg <= {28'h000_0000, decimals, hyst_mode, trig_out};
        ADT_ADDR_WORK: rdata_reg <= calc.working;
        ADT_ADDR_OFF: rdata_reg <= calc.off_level;
        default: begin
          rdata_reg <= '0;
          rresp_reg <= ADT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hyst_set: assert property (calc.done && hyst_mode && calc.working > on_reg
    |=> trig_out) // see R07
    else $error("output not set above switching level");
  a_hyst_clear: assert property (calc.done && hyst_mode && calc.working <= calc.off_level
    |=> !trig_out) // see R08
    else $error("output not cleared at release level");
  a_hyst_hold: assert property (calc.done && hyst_mode && calc.working > calc.off_level
    && calc.working <= on_reg |=> $stable(trig_out)) // see R09
    else $error("output changed inside hysteresis band");
  a_window_in: assert property (calc.done && !hyst_mode && calc.working >= on_reg
    && calc.working < calc.off_level |=> trig_out) // see R10
    else $error("output low inside window");
  a_window_out: assert property (calc.done && !hyst_mode && (calc.working < on_reg
    || calc.working >= calc.off_level) |=> !trig_out) // see R11
    else $error("output high outside window");
  a_out_quiet: assert property (!calc.done |=> $stable(trig_out))
    else $error("output changed without evaluation");
  a_gain_range: assert property (gain_reg >= ADT_GAIN_MIN && gain_reg <= ADT_GAIN_MAX) // see R02
    else $error("gain outside range");
  a_legacy_gain: assert property (wr_fire && wr_addr == ADT_ADDR_GAIN
    && ctrl_reg[ADT_CTRL_LEGACY] && wr_data[31] |=> $stable(gain_reg) ##0
    bvalid_reg && bresp_reg == ADT_RESP_SLVERR) // see R15
    else $error("negative gain taken in legacy mode");
  a_offset_range: assert property (offset_reg >= -ADT_OFFS_LIM
    && offset_reg <= ADT_OFFS_LIM) // see R03
    else $error("offset outside range");
  a_level_range: assert property (on_reg >= -ADT_LEVEL_LIM && on_reg <= ADT_LEVEL_LIM
    && delta_reg >= -ADT_LEVEL_LIM && delta_reg <= ADT_LEVEL_LIM) // see R04 R05
    else $error("level or width outside range");
  a_phys_clamp: assert property (ctrl_reg[ADT_CTRL_PHYS] |-> samp_sel >= 0
    && samp_sel <= ADT_PHYS_MAX) // see R14
    else $error("physical sample outside span");
  a_eval_latency: assert property (vld_s2_reg && !vld_s3_reg && ctrl_reg[ADT_CTRL_RUN]
    |-> ##1 calc.done)
    else $error("evaluation did not complete in one cycle");

  c_hyst_on: cover property (calc.done && hyst_mode ##1 trig_out);
  c_window_on: cover property (calc.done && !hyst_mode ##1 trig_out);
  c_write_err: cover property (bvalid_reg && bresp_reg == ADT_RESP_SLVERR);

endmodule // adt_trigger

//--- adt_trigger_tb.sv
// self-checking testbench of the analog differential trigger
`timescale 1ns/1ns
module adt_trigger_tb;
  import adt_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic aclk = 0, aresetn = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, go = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 4'hf; // write byte lanes, all four unless a scenario narrows them
  logic aw_r, w_r, b_v, ar_r, r_v, s_v, trig;
  logic [1:0] b_rs, r_rs;
  logic [15:0] s_d, g_val = 0;
  int n_mismatch = 0, tests_run = 0;

  always #20 aclk = ~aclk;

  adt_trigger u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(rd), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sampled_value(s_d), .sampled_valid(s_v), .trig_out(trig));
  adt_src_model u_src (.aclk(aclk), .aresetn(aresetn), .go(go), .val(g_val),
    .sampled_value(s_d), .sampled_valid(s_v));

  // ==========================================================================
  // compare, bus and sample tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write; address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    aw_a <= a;
    wd <= d;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (aw_v && aw_r) begin
        ad = 1;
        aw_v <= 0;
      end
      if (w_v && w_r) begin
        dd = 1;
        w_v <= 0;
      end
    end
    do @(posedge aclk); while (!b_v);
    b_r <= 0;
    check({62'h0, b_rs}, {62'h0, er});
  endtask

  // one read, data and response judged together
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    do @(posedge aclk); while (!ar_r);
    ar_v <= 0;
    while (!r_v) @(posedge aclk);
    r_r <= 0;
    check({rd, 30'h0, r_rs}, {ed, 30'h0, er});
  endtask

  // one sample through the source model, then the result level
  task automatic smp(input logic [15:0] v, input logic e);
    @(posedge aclk);
    g_val <= v;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    repeat (14) @(posedge aclk);
    check({63'h0, trig}, {63'h0, e});
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    check({63'h0, trig}, 64'h0);
    rd_chk(ADT_ADDR_CTRL, ADT_CTRL_RST, ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_GAIN, ADT_GAIN_RST, ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_OFF, ADT_ZERO_RST, ADT_RESP_OKAY);
    $display("test reset done");
  endtask

  // negative gain with truncation, then offset
  task automatic t_scale();
    wr(ADT_ADDR_GAIN, 32'(-250), ADT_RESP_OKAY);
    wr(ADT_ADDR_OFFSET, 32'(500), ADT_RESP_OKAY);
    smp(16'h007b, 1'b1);
    rd_chk(ADT_ADDR_WORK, 32'(123 * -250 / 100 + 500), ADT_RESP_OKAY);
    $display("test scale done");
  endtask

  // range edges accepted, one past them refused and not stored
  task automatic t_limits();
    logic [7:0] a[11] = '{ADT_ADDR_GAIN, ADT_ADDR_GAIN, ADT_ADDR_GAIN, ADT_ADDR_GAIN,
      ADT_ADDR_OFFSET, ADT_ADDR_OFFSET, ADT_ADDR_ON, ADT_ADDR_ON, ADT_ADDR_DELTA,
      ADT_ADDR_DELTA, ADT_ADDR_STATUS};
    int d[11] = '{ADT_GAIN_MAX, ADT_GAIN_MAX + 1, ADT_GAIN_MIN, ADT_GAIN_MIN - 1,
      ADT_OFFS_LIM, -ADT_OFFS_LIM - 1, -ADT_LEVEL_LIM, ADT_LEVEL_LIM + 1,
      ADT_LEVEL_LIM, -ADT_LEVEL_LIM - 1, 0};
    for (int i = 0; i < 11; i++) begin
      // odd entries are out of range, the last one hits a read-only register
      wr(a[i], 32'(d[i]), (i % 2 || i == 10) ? ADT_RESP_SLVERR : ADT_RESP_OKAY);
    end
    rd_chk(ADT_ADDR_GAIN, 32'(ADT_GAIN_MIN), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_OFFSET, 32'(ADT_OFFS_LIM), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_ON, 32'(-ADT_LEVEL_LIM), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_DELTA, 32'(ADT_LEVEL_LIM), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_OFF, 32'h0000_0000, ADT_RESP_OKAY);
    rd_chk(8'h20, 32'h0000_0000, ADT_RESP_SLVERR);
    // low lane only: 0x64 merged into the stored -1000 gives -924, still legal
    ws <= 4'h1;
    wr(ADT_ADDR_GAIN, 32'h0000_0064, ADT_RESP_OKAY);
    ws <= 4'hf;
    rd_chk(ADT_ADDR_GAIN, 32'hffff_fc64, ADT_RESP_OKAY);
    $display("test limits done");
  endtask

  // levels 300 and 300 + delta; hysteresis then window
  task automatic t_levels();
    logic [15:0] v[11] = '{250, 300, 301, 251, 250, 299, 300, 349, 350, 320, 200};
    logic e[11] = '{0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0};
    wr(ADT_ADDR_GAIN, 32'(ADT_GAIN_SCALE), ADT_RESP_OKAY);
    wr(ADT_ADDR_OFFSET, 32'h0000_0000, ADT_RESP_OKAY);
    wr(ADT_ADDR_ON, 32'(300), ADT_RESP_OKAY);
    wr(ADT_ADDR_DELTA, 32'(-50), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_OFF, 32'(250), ADT_RESP_OKAY);
    for (int i = 0; i < 11; i++) begin
      if (i == 5) begin
        wr(ADT_ADDR_DELTA, 32'(50), ADT_RESP_OKAY);
      end
      smp(v[i], e[i]);
    end
    $display("test levels done");
  endtask

  // every decimal setting, result unaffected
  task automatic t_dec();
    for (int p = 0; p < 4; p++) begin
      wr(ADT_ADDR_CTRL, 32'(1 + (p << ADT_CTRL_DEC_LSB)), ADT_RESP_OKAY);
      rd_chk(ADT_ADDR_CTRL, 32'(1 + (p << ADT_CTRL_DEC_LSB)), ADT_RESP_OKAY);
      smp((p % 2) ? 16'd200 : 16'd320, !(p % 2));
      rd_chk(ADT_ADDR_STATUS, 32'((p << 2) + !(p % 2)), ADT_RESP_OKAY);
    end
    $display("test decimals done");
  endtask

  // physical channel clamps to 0..1000; older gain range
  task automatic t_phys_legacy();
    wr(ADT_ADDR_CTRL, 32'(1 + (1 << ADT_CTRL_PHYS)), ADT_RESP_OKAY);
    smp(16'd1500, 1'b0);
    rd_chk(ADT_ADDR_WORK, 32'(ADT_PHYS_MAX), ADT_RESP_OKAY);
    smp(16'hfff6, 1'b0);
    rd_chk(ADT_ADDR_WORK, 32'h0000_0000, ADT_RESP_OKAY);
    wr(ADT_ADDR_CTRL, 32'(1 + (1 << ADT_CTRL_LEGACY)), ADT_RESP_OKAY);
    wr(ADT_ADDR_GAIN, 32'(-1), ADT_RESP_SLVERR);
    wr(ADT_ADDR_GAIN, 32'(ADT_GAIN_LEG_MIN), ADT_RESP_OKAY);
    rd_chk(ADT_ADDR_GAIN, 32'(ADT_GAIN_LEG_MIN), ADT_RESP_OKAY);
    $display("test physical and legacy done");
  endtask

  // ==========================================================================
  // verdict, watchdog and main sequence
  task automatic complete_run();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_scale();
    t_limits();
    t_levels();
    t_dec();
    t_phys_legacy();
    complete_run();
  end
endmodule // adt_trigger_tb
